//--- src/rss_sequencer.sv
// Contract
// - stop flag on end, stop cmds, limit zero
// - wait-done flag when fixed and register waits complete
// - opcode B9 sets program flag
// - end of memory keeps program
// - stop commands clear instruction memory
// - immediate strobes unstored, hold program
// - undefined opcodes act as no-op
// - bit7 clear: conditional skip
// - fixed wait counts overflows, zero is 32
// - compare wait until timer >= compare
// - register wait decrements X, zero skips
// - label records loop start
// - repeat jumps to label when true
// - condition codes select seven sources
// - BF decrements Z with wrap
// - BE decrements Y with wrap
// - BD increments Y with wrap
// - capped increment Y to M
// - random load low Y bits of X
// - back-to-back random loads may repeat
// - strobe groups 110 and 111
// - 24-entry memory via write pointer
// - reset fills memory with no-op
// - immediate start runs from zero
// - limit register decrements, halts at zero
module rss_sequencer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic timer_overflow,
    input wire logic timer_ge_compare,
    input wire logic clear_channel,
    input wire logic frame_delimiter,
    input wire logic [7:0] random_source_out,
    output logic strobe_valid,
    output logic [4:0] strobe_select_field,
    output logic strobe_immediate,
    output logic stop_irq_flag,
    output logic wait_done_irq_flag,
    output logic program_irq_flag
);
    localparam int MEM_DEPTH_BITS = rss_pkg::MEM_DEPTH * 8;
    typedef struct packed {
        logic [MEM_DEPTH_BITS-1:0] mem;
        rss_pkg::rss_state_t state;
        logic [4:0] pc;
        logic [4:0] wptr;
        logic [4:0] label;
        logic label_ok;
        logic [5:0] wcnt;
        logic wait_reg;
        logic [7:0] x;
        logic [7:0] y;
        logic [7:0] z;
        logic [7:0] t;
        logic host_cond;
        logic stop_f;
        logic wt_f;
        logic int_f;
        logic sel_v;
        logic [4:0] sel;
        logic sel_i;
        logic aw_ok;
        logic [7:0] awa;
        logic w_ok;
        logic [7:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
        logic ov1;
        logic ov2;
        logic ov3;
        logic ge1;
        logic ge2;
        logic cc1;
        logic cc2;
        logic fd1;
        logic fd2;
    } rss_st_t;

    rss_st_t st_reg;
    rss_st_t st_next;
    logic [7:0] op;
    logic cond;
    logic [7:0] rmask;
    logic [5:0] skip_pc;

    // current opcode and the condition selected by its low bits
    always_comb begin
        op = st_reg.mem[st_reg.pc*8 +: 8];
        case (op[2:0])
            3'h0: cond = st_reg.cc2;
            3'h1: cond = st_reg.fd2;
            3'h2: cond = st_reg.host_cond;
            3'h3: cond = (st_reg.pc == rss_pkg::LAST_LOC);
            3'h4: cond = (st_reg.x == 8'h00);
            3'h5: cond = (st_reg.y == 8'h00);
            3'h6: cond = (st_reg.z == 8'h00);
            default: cond = 1'b0;
        endcase
        rmask = (st_reg.y == 8'h00 || st_reg.y > 8'h08) ? 8'hFF
              : 8'hFF >> (4'h8 - 4'(st_reg.y)); // y is 1 to 8 here
        skip_pc = 6'(st_reg.pc) + 6'(op[6:4]) + 6'h01;
    end

    logic wr_go;
    logic ovf;
    logic imm;
    assign wr_go = st_reg.aw_ok && st_reg.w_ok && !st_reg.bv;
    assign ovf = st_reg.ov2 && !st_reg.ov3; // edge after second stage
    // immediate write under way; the program is held for that cycle
    assign imm = wr_go && st_reg.ws[0] && st_reg.awa == rss_pkg::ADDR_INSTR
        && st_reg.wd[7:5] == rss_pkg::GRP_ISTRB;

    // all next-state logic in one place
    always_comb begin
        logic advance;
        logic halt_clear;
        logic halt_keep;
        advance = 1'b0;
        halt_clear = 1'b0;
        halt_keep = 1'b0;
        st_next = st_reg;
        st_next.sel_v = 1'b0;
        // input synchronisers, first stage only feeds the second
        st_next.ov1 = timer_overflow;
        st_next.ov2 = st_reg.ov1;
        st_next.ov3 = st_reg.ov2;
        st_next.ge1 = timer_ge_compare;
        st_next.ge2 = st_reg.ge1;
        st_next.cc1 = clear_channel;
        st_next.cc2 = st_reg.cc1;
        st_next.fd1 = frame_delimiter;
        st_next.fd2 = st_reg.fd1;
        st_next.stop_f = 1'b0;
        st_next.wt_f = 1'b0;
        st_next.int_f = 1'b0;
        // bus channel capture
        if (s_axi_awvalid && !st_reg.aw_ok) begin
            st_next.aw_ok = 1'b1;
            st_next.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_ok) begin
            st_next.w_ok = 1'b1;
            st_next.wd = s_axi_wdata[7:0];
            st_next.ws = s_axi_wstrb;
        end
        if (st_reg.bv && s_axi_bready) begin
            st_next.bv = 1'b0;
        end
        if (st_reg.rv && s_axi_rready) begin
            st_next.rv = 1'b0;
        end
        // program execution, held while an immediate strobe goes out
        if (!imm && st_reg.state == rss_pkg::RSS_RUN) begin
            if (!op[7]) begin
                if (cond ^ op[3]) begin
                    if (skip_pc > 6'(rss_pkg::LAST_LOC)) halt_keep = 1'b1;
                    else st_next.pc = skip_pc[4:0];
                end else begin
                    advance = 1'b1;
                end
            end else if (op[7:5] == rss_pkg::GRP_WAIT) begin
                st_next.wcnt = (op[4:0] == 5'h00) ? rss_pkg::WAIT_ZERO_CNT : 6'(op[4:0]);
                st_next.wait_reg = 1'b0;
                st_next.state = rss_pkg::RSS_WAIT;
            end else if (op == rss_pkg::OP_CMP_WAIT) begin
                if (st_reg.ge2) advance = 1'b1;
            end else if (op == rss_pkg::OP_WAITREG) begin
                if (st_reg.x == 8'h00) begin
                    advance = 1'b1;
                    st_next.wt_f = 1'b1;
                end else begin
                    st_next.wait_reg = 1'b1;
                    st_next.state = rss_pkg::RSS_WAIT;
                end
            end else if (op == rss_pkg::OP_LABEL) begin
                st_next.label = (st_reg.pc == rss_pkg::LAST_LOC) ? st_reg.pc : st_reg.pc + 5'h01;
                st_next.label_ok = 1'b1;
                advance = 1'b1;
            end else if (op[7:4] == rss_pkg::GRP_REPEAT) begin
                if ((cond ^ op[3]) && st_reg.label_ok) st_next.pc = st_reg.label;
                else advance = 1'b1;
            end else if (op == rss_pkg::OP_INT) begin
                st_next.int_f = 1'b1;
                advance = 1'b1;
            end else if (op == rss_pkg::OP_Y_INC) begin
                st_next.y = st_reg.y + 8'h01;
                advance = 1'b1;
            end else if (op[7:3] == rss_pkg::GRP_CAP) begin
                st_next.y = (st_reg.y == 8'hFF || st_reg.y + 8'h01 > 8'(op[2:0]))
                          ? 8'(op[2:0]) : st_reg.y + 8'h01;
                advance = 1'b1;
            end else if (op == rss_pkg::OP_Y_DEC) begin
                st_next.y = st_reg.y - 8'h01;
                advance = 1'b1;
            end else if (op == rss_pkg::OP_Z_DEC) begin
                st_next.z = st_reg.z - 8'h01;
                advance = 1'b1;
            end else if (op == rss_pkg::OP_RAND) begin
                // sampled straight, a stale value may repeat
                st_next.x = random_source_out & rmask;
                advance = 1'b1;
            end else if (op == rss_pkg::OP_STOP) begin
                halt_clear = 1'b1;
            end else begin
                // strobes and undefined codes; undefined strobes become no-op
                if (op[7:5] == rss_pkg::GRP_PSTRB && op[4:0] <= rss_pkg::SEL_LAST) begin
                    st_next.sel_v = 1'b1;
                    st_next.sel = op[4:0];
                    st_next.sel_i = 1'b0;
                end
                advance = 1'b1;
            end
        end else if (st_reg.state == rss_pkg::RSS_WAIT && ovf) begin
            if (st_reg.wait_reg) begin
                st_next.x = st_reg.x - 8'h01;
                if (st_reg.x == 8'h01) begin
                    st_next.state = rss_pkg::RSS_RUN;
                    advance = 1'b1;
                    st_next.wt_f = 1'b1;
                end
            end else begin
                st_next.wcnt = st_reg.wcnt - 6'h01;
                if (st_reg.wcnt == 6'h01) begin
                    st_next.state = rss_pkg::RSS_RUN;
                    advance = 1'b1;
                    st_next.wt_f = 1'b1;
                end
            end
        end
        if (advance) begin
            if (st_reg.pc == rss_pkg::LAST_LOC) halt_keep = 1'b1;
            else st_next.pc = st_reg.pc + 5'h01;
        end
        // overflow limit countdown while a program is active
        if (st_reg.state != rss_pkg::RSS_IDLE && ovf && st_reg.t != rss_pkg::T_DISABLE) begin
            st_next.t = st_reg.t - 8'h01;
            if (st_reg.t == 8'h01) halt_keep = 1'b1;
        end
        // bus write
        if (wr_go) begin
            st_next.aw_ok = 1'b0;
            st_next.w_ok = 1'b0;
            st_next.bv = 1'b1;
            st_next.br = rss_pkg::RESP_OKAY;
            if (!st_reg.ws[0]) begin
                st_next.br = rss_pkg::RESP_OKAY;
            end else if (st_reg.awa == rss_pkg::ADDR_INSTR) begin
                if (imm) begin
                    if (st_reg.wd == rss_pkg::OP_ISTOP) begin
                        halt_clear = 1'b1;
                    end else if (st_reg.wd == rss_pkg::OP_ISTART) begin
                        st_next.pc = rss_pkg::ZERO_LOC;
                        st_next.state = rss_pkg::RSS_RUN;
                    end else if (st_reg.wd[4:0] <= rss_pkg::SEL_LAST) begin
                        st_next.sel_v = 1'b1;
                        st_next.sel = st_reg.wd[4:0];
                        st_next.sel_i = 1'b1;
                    end
                end else if (st_reg.wptr != 5'(rss_pkg::MEM_DEPTH)) begin
                    st_next.mem[st_reg.wptr*8 +: 8] = st_reg.wd;
                    st_next.wptr = st_reg.wptr + 5'h01;
                end
            end else if (st_reg.awa == rss_pkg::ADDR_X) begin
                st_next.x = st_reg.wd;
            end else if (st_reg.awa == rss_pkg::ADDR_Y) begin
                st_next.y = st_reg.wd;
            end else if (st_reg.awa == rss_pkg::ADDR_Z) begin
                st_next.z = st_reg.wd;
            end else if (st_reg.awa == rss_pkg::ADDR_T) begin
                st_next.t = st_reg.wd;
            end else if (st_reg.awa == rss_pkg::ADDR_CTRL) begin
                st_next.host_cond = st_reg.wd[0];
            end else if (st_reg.awa != rss_pkg::ADDR_STATUS) begin
                st_next.br = rss_pkg::RESP_SLVERR;
            end
        end
        if (halt_keep || halt_clear) begin
            st_next.state = rss_pkg::RSS_IDLE;
            st_next.pc = rss_pkg::ZERO_LOC;
            st_next.stop_f = 1'b1;
        end
        if (halt_clear) begin
            st_next.mem = {rss_pkg::MEM_DEPTH{rss_pkg::OP_NOP}};
            st_next.wptr = rss_pkg::ZERO_LOC;
            st_next.label_ok = 1'b0;
        end
        // bus read
        if (s_axi_arvalid && !st_reg.rv) begin
            st_next.rv = 1'b1;
            st_next.rr = rss_pkg::RESP_OKAY;
            st_next.rd = 32'h0000_0000;
            if (s_axi_araddr == rss_pkg::ADDR_INSTR) begin
                st_next.rd[7:0] = (st_reg.state == rss_pkg::RSS_IDLE) ? rss_pkg::OP_NOP : op;
            end else if (s_axi_araddr == rss_pkg::ADDR_X) begin
                st_next.rd[7:0] = st_reg.x;
            end else if (s_axi_araddr == rss_pkg::ADDR_Y) begin
                st_next.rd[7:0] = st_reg.y;
            end else if (s_axi_araddr == rss_pkg::ADDR_Z) begin
                st_next.rd[7:0] = st_reg.z;
            end else if (s_axi_araddr == rss_pkg::ADDR_T) begin
                st_next.rd[7:0] = st_reg.t;
            end else if (s_axi_araddr == rss_pkg::ADDR_CTRL) begin
                st_next.rd[0] = st_reg.host_cond;
            end else if (s_axi_araddr == rss_pkg::ADDR_STATUS) begin
                st_next.rd[1:0] = st_reg.state;
                st_next.rd[12:8] = st_reg.pc;
                st_next.rd[20:16] = st_reg.wptr;
            end else begin
                st_next.rr = rss_pkg::RESP_SLVERR;
            end
        end
    end

    // single state register, memory preset to no-op
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.mem <= {rss_pkg::MEM_DEPTH{rss_pkg::OP_NOP}};
            st_reg.t <= rss_pkg::T_DISABLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = !st_reg.aw_ok;
    assign s_axi_wready = !st_reg.w_ok;
    assign s_axi_bvalid = st_reg.bv;
    assign s_axi_bresp = st_reg.br;
    assign s_axi_arready = !st_reg.rv;
    assign s_axi_rvalid = st_reg.rv;
    assign s_axi_rdata = st_reg.rd;
    assign s_axi_rresp = st_reg.rr;
    assign strobe_valid = st_reg.sel_v;
    assign strobe_select_field = st_reg.sel;
    assign strobe_immediate = st_reg.sel_i;
    assign stop_irq_flag = st_reg.stop_f;
    assign wait_done_irq_flag = st_reg.wt_f;
    assign program_irq_flag = st_reg.int_f;

    // checks
    int_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_reg.state == rss_pkg::RSS_RUN && op == rss_pkg::OP_INT && !imm)
        |=> program_irq_flag) else $error("int opcode gave no flag");
    stop_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_reg.state == rss_pkg::RSS_RUN && op == rss_pkg::OP_STOP && !imm)
        |=> stop_irq_flag && st_reg.wptr == 5'h00
        && st_reg.mem[7:0] == rss_pkg::OP_NOP) else $error("stop did not clear");
    z_dec_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_reg.state == rss_pkg::RSS_RUN && op == rss_pkg::OP_Z_DEC && !imm)
        |=> st_reg.z == $past(st_reg.z) - 8'h01) else $error("z not decremented");
    y_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_reg.state == rss_pkg::RSS_RUN && op == rss_pkg::OP_Y_INC && !imm)
        |=> st_reg.y == $past(st_reg.y) + 8'h01) else $error("y not incremented");
    end_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_reg.state == rss_pkg::RSS_RUN && st_reg.pc == rss_pkg::LAST_LOC
        && op == rss_pkg::OP_NOP && !imm)
        |=> stop_irq_flag && st_reg.mem == $past(st_reg.mem)) else $error("end lost program");
    wait_done_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_reg.state == rss_pkg::RSS_WAIT && ovf && !st_reg.wait_reg && st_reg.wcnt == 6'h01
        && st_reg.t != 8'h01)
        |=> wait_done_irq_flag && st_reg.state == rss_pkg::RSS_RUN) else $error("wait end");
    register_count_wait_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_reg.state == rss_pkg::RSS_RUN && op == rss_pkg::OP_WAITREG
        && st_reg.x == 8'h00 && !imm)
        |=> st_reg.state != rss_pkg::RSS_WAIT) else $error("waited on zero x");
    imm_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (imm && st_reg.state == rss_pkg::RSS_RUN && st_reg.wd != rss_pkg::OP_ISTOP
        && st_reg.wd != rss_pkg::OP_ISTART)
        |=> $stable(st_reg.pc) && $stable(st_reg.wptr)) else $error("immediate moved program");
    run_cov: cover property (@(posedge clk) disable iff (!rst_n)
        st_reg.state == rss_pkg::RSS_IDLE ##1 st_reg.state == rss_pkg::RSS_RUN);
    wait_cov: cover property (@(posedge clk) disable iff (!rst_n) wait_done_irq_flag);
    sel_cov: cover property (@(posedge clk) disable iff (!rst_n) strobe_valid && !strobe_immediate);
endmodule // rss_sequencer

//--- src/rss_pkg.sv
package rss_pkg;
    // register byte addresses on the bus
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_X = 8'h04;
    localparam logic [7:0] ADDR_Y = 8'h08;
    localparam logic [7:0] ADDR_Z = 8'h0C;
    localparam logic [7:0] ADDR_T = 8'h10;
    localparam logic [7:0] ADDR_CTRL = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    // memory geometry
    localparam int MEM_DEPTH = 24;
    localparam logic [4:0] LAST_LOC = 5'h17;
    localparam logic [4:0] ZERO_LOC = 5'h00;
    // opcodes
    localparam logic [7:0] OP_NOP = 8'hC0;
    localparam logic [7:0] OP_STOP = 8'hDF;
    localparam logic [7:0] OP_ISTOP = 8'hFF;
    localparam logic [7:0] OP_ISTART = 8'hFE;
    localparam logic [7:0] OP_CMP_WAIT = 8'hB8;
    localparam logic [7:0] OP_INT = 8'hB9;
    localparam logic [7:0] OP_LABEL = 8'hBA;
    localparam logic [7:0] OP_WAITREG = 8'hBB;
    localparam logic [7:0] OP_RAND = 8'hBC;
    localparam logic [7:0] OP_Y_INC = 8'hBD;
    localparam logic [7:0] OP_Y_DEC = 8'hBE;
    localparam logic [7:0] OP_Z_DEC = 8'hBF;
    localparam logic [2:0] GRP_WAIT = 3'h4;
    localparam logic [3:0] GRP_REPEAT = 4'hA;
    localparam logic [4:0] GRP_CAP = 5'h16;
    localparam logic [2:0] GRP_PSTRB = 3'h6;
    localparam logic [2:0] GRP_ISTRB = 3'h7;
    localparam logic [4:0] SEL_LAST = 5'h0A;
    localparam logic [7:0] T_DISABLE = 8'hFF;
    localparam logic [5:0] WAIT_ZERO_CNT = 6'h20;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        RSS_IDLE = 2'b00,
        RSS_RUN = 2'b01,
        RSS_WAIT = 2'b10
    } rss_state_t;
endpackage

//--- testbench/rss_far_model.sv
module rss_far_model (
    input wire logic clk,
    input wire logic rst_n,
    output logic timer_overflow
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] tick_reg;
    // mac timer wraps every 8 cycles, short so waits stay cheap
    always @(posedge clk) begin
        if (!rst_n) begin
            tick_reg <= 3'h0;
        end else begin
            tick_reg <= tick_reg + 3'h1;
        end
    end
    // overflow is a one-cycle event, never a level
    assign timer_overflow = (tick_reg == 3'h7);
endmodule // rss_far_model

//--- testbench/radio_strobe_sequencer_tb.sv
module radio_strobe_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, rst_n = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, random_source_out = 8'hA5;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seen_imm = 32'h0, seen_prg = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic timer_overflow, timer_ge_compare = 1'h1, clear_channel = 1'h0, frame_delimiter = 1'h0;
    logic strobe_valid, strobe_immediate, stop_irq_flag, wait_done_irq_flag, program_irq_flag;
    logic [4:0] strobe_select_field;
    logic [7:0] prog[$];
    int n_fail = 0, compares = 0, cycles = 0, n_stop = 0, n_wait = 0, n_prog = 0;
    int s_stop, s_wait, s_prog, c0;

    always #25 clk = ~clk;

    rss_sequencer dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_overflow, .timer_ge_compare,
        .clear_channel, .frame_delimiter, .random_source_out, .strobe_valid,
        .strobe_select_field, .strobe_immediate, .stop_irq_flag, .wait_done_irq_flag,
        .program_irq_flag);
    rss_far_model far (.clk, .rst_n, .timer_overflow);

    // flag pulses and strobes tallied here; timeout guards every unbounded wait
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (stop_irq_flag === 1'h1) n_stop <= n_stop + 1;
        if (wait_done_irq_flag === 1'h1) n_wait <= n_wait + 1;
        if (program_irq_flag === 1'h1) n_prog <= n_prog + 1;
        if (strobe_valid === 1'h1 && strobe_immediate === 1'h1) seen_imm[strobe_select_field] <= 1'h1;
        if (strobe_valid === 1'h1 && strobe_immediate === 1'h0) seen_prg[strobe_select_field] <= 1'h1;
        if (cycles == 20000) begin
            $display("unexpected %0t run too long", $time);
            n_fail = n_fail + 1;
            results();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected %0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (s_axi_awvalid === 1'h1 && s_axi_awready === 1'h1) begin
                aw_ok = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wvalid === 1'h1 && s_axi_wready === 1'h1) begin
                w_ok = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        while (s_axi_bvalid !== 1'h1) @(posedge clk);
        chk({30'h0, s_axi_bresp}, {30'h0, rss_pkg::RESP_OKAY});
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        while (s_axi_rvalid !== 1'h1) @(posedge clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk({22'h0, r, d[7:0]}, {22'h0, rss_pkg::RESP_OKAY, e});
    endtask

    // snapshot counters before the start so only this run is judged
    task automatic go();
        s_stop = n_stop;
        s_wait = n_wait;
        s_prog = n_prog;
        c0 = cycles;
        wr(rss_pkg::ADDR_INSTR, rss_pkg::OP_ISTART);
    endtask

    task automatic run();
        wr(rss_pkg::ADDR_INSTR, rss_pkg::OP_ISTOP);
        foreach (prog[j]) wr(rss_pkg::ADDR_INSTR, prog[j]);
        go();
    endtask

    task automatic wait_stop();
        int k;
        k = 0;
        while (n_stop == s_stop && k < 3000) begin
            @(posedge clk);
            k = k + 1;
        end
        chk(32'(n_stop - s_stop), 32'h1);
    endtask

    task automatic t_regs();
        wr(rss_pkg::ADDR_Y, 8'hFF);
        wr(rss_pkg::ADDR_Z, 8'h00);
        prog = {rss_pkg::OP_Y_INC, 8'hCF, rss_pkg::OP_Z_DEC, rss_pkg::OP_INT};
        run();
        wait_stop();
        rc(rss_pkg::ADDR_Y, 8'h00);
        rc(rss_pkg::ADDR_Z, 8'hFF);
        chk(32'(n_prog - s_prog), 32'h1);
        go();
        wait_stop();
        rc(rss_pkg::ADDR_Y, 8'h01);
        rc(rss_pkg::ADDR_Z, 8'hFE);
    endtask

    // all-ones Y capped, cap of zero, wrap below zero, then stop clears memory
    task automatic t_stop();
        logic [31:0] d;
        logic [1:0] r;
        wr(rss_pkg::ADDR_Y, 8'hFF);
        prog = {8'hB7, 8'hB0, rss_pkg::OP_Y_DEC, 8'hB5, rss_pkg::OP_STOP};
        run();
        wait_stop();
        rc(rss_pkg::ADDR_Y, 8'h05);
        rd(rss_pkg::ADDR_STATUS, d, r);
        chk({27'h0, d[20:16]}, 32'h0);
        wr(rss_pkg::ADDR_Y, 8'h02);
        go();
        wait_stop();
        rc(rss_pkg::ADDR_Y, 8'h02);
    endtask

    task automatic t_rand_wait();
        wr(rss_pkg::ADDR_Y, 8'h03);
        prog = {rss_pkg::OP_RAND};
        run();
        wait_stop();
        rc(rss_pkg::ADDR_X, 8'h05);
        wr(rss_pkg::ADDR_Y, 8'h00);
        run();
        wait_stop();
        rc(rss_pkg::ADDR_X, 8'hA5);
        wr(rss_pkg::ADDR_X, 8'h02);
        prog = {8'h82, rss_pkg::OP_WAITREG};
        run();
        wait_stop();
        chk(32'(n_wait - s_wait), 32'h2);
        rc(rss_pkg::ADDR_X, 8'h00);
        prog = {8'h80};
        run();
        wait_stop();
        chk(32'((cycles - c0) inside {[248:290]}), 32'h1);
        wr(rss_pkg::ADDR_T, 8'h03);
        run();
        wait_stop();
        chk(32'(n_wait - s_wait), 32'h0);
        rc(rss_pkg::ADDR_T, 8'h00);
        wr(rss_pkg::ADDR_T, rss_pkg::T_DISABLE);
    endtask

    // skip sweeps six condition cases, then loop and compare wait are run on their own
    task automatic t_flow();
        logic [7:0] ops[6] = '{8'h14, 8'h1C, 8'h12, 8'h15, 8'h10, 8'h11};
        logic hit[6] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
        wr(rss_pkg::ADDR_X, 8'h00);
        wr(rss_pkg::ADDR_Y, 8'h05);
        wr(rss_pkg::ADDR_CTRL, 8'h01);
        clear_channel <= 1'h1;
        for (int j = 0; j < 6; j++) begin
            prog = {ops[j], rss_pkg::OP_INT};
            run();
            wait_stop();
            chk(32'(n_prog - s_prog), {31'h0, hit[j]});
        end
        wr(rss_pkg::ADDR_Y, 8'hFE);
        prog = {rss_pkg::OP_LABEL, rss_pkg::OP_Y_INC, 8'hAD};
        run();
        wait_stop();
        rc(rss_pkg::ADDR_Y, 8'h00);
        wr(rss_pkg::ADDR_Y, 8'hFE);
        prog = {rss_pkg::OP_Y_INC, 8'hAD};
        run();
        wait_stop();
        rc(rss_pkg::ADDR_Y, 8'hFF);
        timer_ge_compare <= 1'h0;
        prog = {rss_pkg::OP_CMP_WAIT, rss_pkg::OP_INT};
        run();
        wr(rss_pkg::ADDR_INSTR, 8'hE2);
        repeat (30) @(posedge clk);
        chk(32'(n_prog - s_prog), 32'h0);
        timer_ge_compare <= 1'h1;
        wait_stop();
        chk(32'(n_prog - s_prog), 32'h1);
    endtask

    task automatic t_strobes();
        logic [31:0] d;
        logic [1:0] r;
        prog = {};
        for (int j = 1; j < 11; j++) prog.push_back(8'hC0 | 8'(j));
        run();
        wait_stop();
        chk({22'h0, seen_prg[10:1]}, 32'h3FF);
        for (int j = 1; j < 11; j++) wr(rss_pkg::ADDR_INSTR, 8'hE0 | 8'(j));
        for (int k = 0; k < 20 && seen_imm[10:1] !== 10'h3FF; k++) @(posedge clk);
        chk({22'h0, seen_imm[10:1]}, 32'h3FF);
        rd(rss_pkg::ADDR_STATUS, d, r);
        chk({27'h0, d[20:16]}, 32'hA);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        wr(rss_pkg::ADDR_Y, 8'h07);
        go();
        wait_stop();
        rc(rss_pkg::ADDR_Y, 8'h07);
        rc(rss_pkg::ADDR_T, rss_pkg::T_DISABLE);
        t_regs();
        t_stop();
        t_rand_wait();
        t_flow();
        t_strobes();
        results();
    end
endmodule // radio_strobe_sequencer_tb
